//--- rtl/dbm_buffer_manager.v
// descriptor-driven transmit gather and receive buffer manager
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defines.vh"

module dbm_buffer_manager #(
    parameter EOBC_WORDS = 16'd760 // least free words before a packet starts
) (
    input  wire        clk_in,
    input  wire        nrst_in,
    // memory master port, one 16-bit access per ack
    output wire        mem_req_out,
    output wire        mem_we_out,
    output wire [31:0] mem_addr_out,
    output wire [15:0] mem_wdata_out,
    input  wire        mem_ack_in,
    input  wire [15:0] mem_rdata_in,
    // transmit control
    input  wire [15:0] tx_upper_in,
    input  wire [15:0] tx_first_desc_in,
    input  wire        tx_start_in,
    output wire        tx_busy_out,
    output reg  [15:0] tx_pkt_size_out,
    // transmit byte stream to the mac
    output reg  [7:0]  tx_data_out,
    output reg         tx_valid_out,
    output reg         tx_last_out,
    input  wire        tx_ready_in,
    input  wire        tx_status_valid_in,
    input  wire [15:0] tx_status_in,
    // receive control
    input  wire        rx_enable_in,
    input  wire [15:0] rx_desc_upper_in,
    input  wire [15:0] rx_first_desc_in,
    input  wire [15:0] rsrc_upper_in,
    input  wire [15:0] rsrc_start_in,
    input  wire [15:0] rsrc_end_in,
    input  wire [15:0] rsrc_write_ptr_in,
    output wire        rx_desc_exhausted_out,
    output wire        rx_rsrc_empty_out,
    output reg         rx_pkt_done_out,
    // receive word stream from the mac
    input  wire        rx_valid_in,
    output wire        rx_ready_out,
    input  wire [15:0] rx_data_in,
    input  wire        rx_last_in,
    input  wire        rx_last_odd_in,
    input  wire [15:0] rx_status_in
);
    // transmit states
    localparam T_IDLE = 4'h0, T_SIZE = 4'h1, T_CNT = 4'h2, T_FP0 = 4'h3, T_FP1 = 4'h4;
    localparam T_FSZ = 4'h5, T_DATA = 4'h6, T_WST = 4'h7, T_WRST = 4'h8, T_LINK = 4'h9;
    // receive states
    localparam R_IDLE = 4'h0, R_RS0 = 4'h1, R_RS1 = 4'h2, R_RS2 = 4'h3, R_RS3 = 4'h4;
    localparam R_DATA = 4'h5, R_WST = 4'h6, R_WBC = 4'h7, R_WP0 = 4'h8, R_WP1 = 4'h9;
    localparam R_LINK = 4'hA, R_USE = 4'hB;

    reg  [3:0]  tx_state_reg;    // transmit sequencer
    reg  [15:0] tx_off_reg;      // current transmit descriptor offset
    reg  [15:0] frag_left_reg;   // fragments still to fetch
    reg  [15:0] frag_idx_reg;    // field index of current fragment
    reg  [31:0] frag_ptr_reg;    // byte pointer inside fragment
    reg  [15:0] frag_bytes_reg;  // bytes left in fragment
    reg  [15:0] tx_stat_reg;     // status latched from the mac
    reg  [3:0]  rx_state_reg;    // receive sequencer
    reg  [15:0] rx_off_reg;      // current receive descriptor offset
    reg  [15:0] rrp_reg;         // resource read pointer
    reg  [31:0] buf_ptr_reg;     // next free byte in receive buffer
    reg  [31:0] buf_left_reg;    // free words left in receive buffer
    reg  [31:0] pkt_start_reg;   // where the current packet began
    reg  [15:0] pkt_words_reg;   // words of current packet
    reg         pkt_odd_reg;     // last word held one byte
    reg  [15:0] rx_stat_reg;     // receive status latched at end
    reg         exhaust_reg;     // descriptor list ran out
    reg         busy_reg;        // a granted access is pending
    reg         owner_rx_reg;    // which sequencer holds the bus

    wire [17:0] rxb_data;        // buffered receive word + flags
    wire        rxb_valid;
    wire        tx_ack;
    wire        rx_ack;
    reg         tx_req;
    reg         tx_we;
    reg  [31:0] tx_addr;
    reg  [15:0] tx_wdata;
    reg         rx_req;
    reg  [31:0] rx_addr;
    reg  [15:0] rx_wdata;

    // descriptor address: fixed upper half, offset plus field index
    function [31:0] dbm_field_addr;
        input [15:0] upper;
        input [15:0] off;
        input [15:0] idx;
        begin
            dbm_field_addr = {upper, off + (idx << `DBM_FIELD_SHIFT)};
        end
    endfunction

    // receive words wait here while the bus serves transmit
    dbm_skid_buffer #(.WIDTH(18), .DEPTH(2)) u_rx_buf (
        .clk_in        (clk_in),
        .nrst_in       (nrst_in),
        .in_valid_in   (rx_valid_in),
        .in_ready_out  (rx_ready_out),
        .in_data_in    ({rx_last_odd_in, rx_last_in, rx_data_in}),
        .out_valid_out (rxb_valid),
        .out_ready_in  (rx_ack & (rx_state_reg == R_DATA)),
        .out_data_out  (rxb_data)
    );

    // receive reads: resource entries and the link; the resource area is never written
    wire rx_is_read = (rx_state_reg == R_RS0) | (rx_state_reg == R_RS1) |
                      (rx_state_reg == R_RS2) | (rx_state_reg == R_RS3) |
                      (rx_state_reg == R_LINK);
    // arbiter: receive wins a free bus, a grant holds until its ack
    wire grant_rx = busy_reg ? owner_rx_reg : rx_req;
    assign mem_req_out   = grant_rx ? rx_req : tx_req;
    assign mem_we_out    = grant_rx ? ~rx_is_read : tx_we;
    assign mem_addr_out  = grant_rx ? rx_addr : tx_addr;
    assign mem_wdata_out = grant_rx ? rx_wdata : tx_wdata;
    assign tx_ack        = mem_ack_in & ~grant_rx & tx_req;
    assign rx_ack        = mem_ack_in & grant_rx & rx_req;

    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy_reg     <= 1'b0;
            owner_rx_reg <= 1'b0;
        end else begin
            busy_reg     <= mem_req_out & ~mem_ack_in;
            owner_rx_reg <= grant_rx;
        end
    end

    // transmit bus request from current state
    always @* begin
        tx_req   = 1'b1;
        tx_we    = 1'b0;
        tx_wdata = tx_stat_reg;
        tx_addr  = dbm_field_addr(tx_upper_in, tx_off_reg, `DBM_TXD_PKT_SIZE);
        case (tx_state_reg)
            T_SIZE: tx_addr = dbm_field_addr(tx_upper_in, tx_off_reg, `DBM_TXD_PKT_SIZE);
            T_CNT:  tx_addr = dbm_field_addr(tx_upper_in, tx_off_reg, `DBM_TXD_FRAG_COUNT);
            T_FP0:  tx_addr = dbm_field_addr(tx_upper_in, tx_off_reg, frag_idx_reg);
            T_FP1:  tx_addr = dbm_field_addr(tx_upper_in, tx_off_reg, frag_idx_reg + 16'h1);
            T_FSZ:  tx_addr = dbm_field_addr(tx_upper_in, tx_off_reg, frag_idx_reg + 16'h2);
            // fragments may start on any byte, so data is fetched bytewise
            T_DATA: begin
                tx_addr = frag_ptr_reg;
                tx_req  = ~tx_valid_out | tx_ready_in;
            end
            T_WRST: begin
                tx_addr = dbm_field_addr(tx_upper_in, tx_off_reg, `DBM_TXD_STATUS);
                tx_we   = 1'b1;
            end
            // link field follows the last fragment entry
            T_LINK: tx_addr = dbm_field_addr(tx_upper_in, tx_off_reg, frag_idx_reg);
            default: tx_req = 1'b0;
        endcase
    end

    assign tx_busy_out = (tx_state_reg != T_IDLE);

    // transmit sequencer
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_state_reg    <= T_IDLE;
            tx_off_reg      <= `DBM_OFF_RESET;
            frag_left_reg   <= 16'h0000;
            frag_idx_reg    <= 16'h0000;
            frag_ptr_reg    <= 32'h0000_0000;
            frag_bytes_reg  <= 16'h0000;
            tx_stat_reg     <= 16'h0000;
            tx_pkt_size_out <= 16'h0000;
            tx_data_out     <= 8'h00;
            tx_valid_out    <= 1'b0;
            tx_last_out     <= 1'b0;
        end else begin
            if (tx_valid_out & tx_ready_in) begin
                tx_valid_out <= 1'b0;
            end
            case (tx_state_reg)
                // host loads the first descriptor, then commands
                T_IDLE: if (tx_start_in) begin
                    tx_off_reg   <= tx_first_desc_in;
                    tx_state_reg <= T_SIZE;
                end
                T_SIZE: if (tx_ack) begin
                    tx_pkt_size_out <= mem_rdata_in;
                    tx_state_reg    <= T_CNT;
                end
                T_CNT: if (tx_ack) begin
                    frag_left_reg <= mem_rdata_in;
                    frag_idx_reg  <= `DBM_TXD_FRAG_BASE;
                    tx_state_reg  <= (mem_rdata_in == 16'h0000) ? T_WST : T_FP0;
                end
                T_FP0: if (tx_ack) begin
                    frag_ptr_reg[15:0] <= mem_rdata_in;
                    tx_state_reg       <= T_FP1;
                end
                T_FP1: if (tx_ack) begin
                    frag_ptr_reg[31:16] <= mem_rdata_in;
                    tx_state_reg        <= T_FSZ;
                end
                T_FSZ: if (tx_ack) begin
                    frag_bytes_reg <= mem_rdata_in;
                    frag_idx_reg   <= frag_idx_reg + `DBM_TXD_FRAG_WORDS;
                    frag_left_reg  <= frag_left_reg - 16'h1;
                    tx_state_reg   <= (mem_rdata_in == 16'h0000) ?
                                      ((frag_left_reg == 16'h1) ? T_WST : T_FP0) : T_DATA;
                end
                // gather bytes of every fragment into one packet
                T_DATA: if (tx_ack) begin
                    tx_data_out    <= mem_rdata_in[7:0];
                    tx_valid_out   <= 1'b1;
                    tx_last_out    <= (frag_bytes_reg == 16'h1) & (frag_left_reg == 16'h0);
                    frag_ptr_reg   <= frag_ptr_reg + 32'h1;
                    frag_bytes_reg <= frag_bytes_reg - 16'h1;
                    if (frag_bytes_reg == 16'h1) begin
                        tx_state_reg <= (frag_left_reg == 16'h0) ? T_WST : T_FP0;
                    end
                end
                T_WST: if (tx_status_valid_in) begin
                    tx_stat_reg  <= tx_status_in;
                    tx_state_reg <= T_WRST;
                end
                // status goes back before the link is followed
                T_WRST: if (tx_ack) begin
                    tx_state_reg <= T_LINK;
                end
                // follow the link, end of list returns to idle
                T_LINK: if (tx_ack) begin
                    if (mem_rdata_in[`DBM_LINK_EOL_BIT]) begin
                        tx_state_reg <= T_IDLE;
                    end else begin
                        tx_off_reg   <= {mem_rdata_in[15:1], 1'b0};
                        tx_state_reg <= T_SIZE;
                    end
                end
                default: tx_state_reg <= T_IDLE;
            endcase
        end
    end

    // circular resource queue is empty when read meets write
    assign rx_rsrc_empty_out     = (rrp_reg == rsrc_write_ptr_in);
    assign rx_desc_exhausted_out = exhaust_reg;
    wire [15:0] rrp_step = rrp_reg + `DBM_RSRC_STRIDE;
    wire [15:0] byte_cnt = {pkt_words_reg[14:0], 1'b0} - {15'h0000, pkt_odd_reg};

    // receive bus request from current state
    always @* begin
        rx_req   = 1'b1;
        rx_wdata = rx_stat_reg;
        rx_addr  = dbm_field_addr(rsrc_upper_in, rrp_reg, 16'h0000);
        case (rx_state_reg)
            R_RS0: rx_addr = dbm_field_addr(rsrc_upper_in, rrp_reg, 16'h0000);
            R_RS1: rx_addr = dbm_field_addr(rsrc_upper_in, rrp_reg, 16'h0001);
            R_RS2: rx_addr = dbm_field_addr(rsrc_upper_in, rrp_reg, 16'h0002);
            R_RS3: rx_addr = dbm_field_addr(rsrc_upper_in, rrp_reg, 16'h0003);
            R_DATA: begin
                rx_req   = rxb_valid;
                rx_addr  = buf_ptr_reg;
                rx_wdata = rxb_data[15:0];
            end
            R_WST: rx_addr = dbm_field_addr(rx_desc_upper_in, rx_off_reg, `DBM_RXD_STATUS);
            R_WBC: begin
                rx_addr  = dbm_field_addr(rx_desc_upper_in, rx_off_reg, `DBM_RXD_BYTE_COUNT);
                rx_wdata = byte_cnt;
            end
            R_WP0: begin
                rx_addr  = dbm_field_addr(rx_desc_upper_in, rx_off_reg, `DBM_RXD_PTR0);
                rx_wdata = pkt_start_reg[15:0];
            end
            R_WP1: begin
                rx_addr  = dbm_field_addr(rx_desc_upper_in, rx_off_reg, `DBM_RXD_PTR1);
                rx_wdata = pkt_start_reg[31:16];
            end
            R_LINK: rx_addr = dbm_field_addr(rx_desc_upper_in, rx_off_reg, `DBM_RXD_LINK);
            R_USE: begin
                rx_addr  = dbm_field_addr(rx_desc_upper_in, rx_off_reg, `DBM_RXD_IN_USE);
                rx_wdata = `DBM_IN_USE_DONE;
            end
            default: rx_req = 1'b0;
        endcase
    end

    // receive sequencer
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_state_reg    <= R_IDLE;
            rx_off_reg      <= `DBM_OFF_RESET;
            rrp_reg         <= `DBM_OFF_RESET;
            buf_ptr_reg     <= 32'h0000_0000;
            buf_left_reg    <= `DBM_WC_RESET;
            pkt_start_reg   <= 32'h0000_0000;
            pkt_words_reg   <= 16'h0000;
            pkt_odd_reg     <= 1'b0;
            rx_stat_reg     <= 16'h0000;
            exhaust_reg     <= 1'b1;
            rx_pkt_done_out <= 1'b0;
        end else begin
            rx_pkt_done_out <= 1'b0;
            case (rx_state_reg)
                // enabling reloads queue start and first descriptor
                R_IDLE: if (!rx_enable_in) begin
                    exhaust_reg <= 1'b1;
                end else if (exhaust_reg) begin
                    rx_off_reg  <= rx_first_desc_in;
                    rrp_reg     <= rsrc_start_in;
                    exhaust_reg <= 1'b0;
                end else if (buf_left_reg < {16'h0000, EOBC_WORDS}) begin
                    // too little room for a whole packet: next resource
                    if (!rx_rsrc_empty_out) begin
                        rx_state_reg <= R_RS0;
                    end
                end else if (rxb_valid) begin
                    pkt_start_reg <= buf_ptr_reg;
                    pkt_words_reg <= 16'h0000;
                    rx_state_reg  <= R_DATA;
                end
                R_RS0: if (rx_ack) begin
                    buf_ptr_reg[15:0] <= mem_rdata_in;
                    rx_state_reg      <= R_RS1;
                end
                R_RS1: if (rx_ack) begin
                    buf_ptr_reg[31:16] <= mem_rdata_in;
                    rx_state_reg       <= R_RS2;
                end
                R_RS2: if (rx_ack) begin
                    buf_left_reg[15:0] <= mem_rdata_in;
                    rx_state_reg       <= R_RS3;
                end
                // advance read pointer, wrapping at the end
                R_RS3: if (rx_ack) begin
                    buf_left_reg[31:16] <= mem_rdata_in;
                    rrp_reg      <= (rrp_step == rsrc_end_in) ? rsrc_start_in : rrp_step;
                    rx_state_reg <= R_IDLE;
                end
                // words land back to back in one buffer
                R_DATA: if (rx_ack) begin
                    buf_ptr_reg   <= buf_ptr_reg + 32'h2;
                    buf_left_reg  <= buf_left_reg - 32'h1;
                    pkt_words_reg <= pkt_words_reg + 16'h1;
                    if (rxb_data[16]) begin
                        pkt_odd_reg  <= rxb_data[17];
                        rx_stat_reg  <= rx_status_in;
                        rx_state_reg <= R_WST;
                    end
                end
                // descriptor bound to the packet only now
                R_WST: if (rx_ack) begin
                    rx_state_reg <= R_WBC;
                end
                R_WBC: if (rx_ack) begin
                    rx_state_reg <= R_WP0;
                end
                R_WP0: if (rx_ack) begin
                    rx_state_reg <= R_WP1;
                end
                R_WP1: if (rx_ack) begin
                    rx_state_reg <= R_LINK;
                end
                // end of list flags exhaustion; while still enabled, idle reloads the first descriptor and queue start
                R_LINK: if (rx_ack) begin
                    if (mem_rdata_in[`DBM_LINK_EOL_BIT]) begin
                        exhaust_reg  <= 1'b1;
                        rx_state_reg <= R_IDLE;
                        rx_pkt_done_out <= 1'b1;
                    end else begin
                        rx_stat_reg  <= mem_rdata_in;
                        rx_state_reg <= R_USE;
                    end
                end
                // hand descriptor to software, then move to the next one
                R_USE: if (rx_ack) begin
                    rx_off_reg      <= {rx_stat_reg[15:1], 1'b0};
                    rx_pkt_done_out <= 1'b1;
                    rx_state_reg    <= R_IDLE;
                end
                default: rx_state_reg <= R_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

//--- rtl/dbm_defines.vh
// field offsets, strides and constants of the descriptor buffer manager
`ifndef DBM_DEFINES_VH
`define DBM_DEFINES_VH

// every descriptor field is a 16-bit word on a long-word boundary
`define DBM_FIELD_SHIFT    2
// transmit descriptor field indices
`define DBM_TXD_STATUS     16'h0000
`define DBM_TXD_PKT_SIZE   16'h0001
`define DBM_TXD_FRAG_COUNT 16'h0002
`define DBM_TXD_FRAG_BASE  16'h0003
`define DBM_TXD_FRAG_WORDS 16'h0003
// receive descriptor field indices
`define DBM_RXD_STATUS     16'h0000
`define DBM_RXD_BYTE_COUNT 16'h0001
`define DBM_RXD_PTR0       16'h0002
`define DBM_RXD_PTR1       16'h0003
`define DBM_RXD_LINK       16'h0004
`define DBM_RXD_IN_USE     16'h0005
// resource entry: ptr0, ptr1, wc0, wc1
`define DBM_RSRC_STRIDE    16'h0010
// link bit 0 marks the end of a list
`define DBM_LINK_EOL_BIT   0
`define DBM_IN_USE_DONE    16'h0000
`define DBM_OFF_RESET      16'h0000
`define DBM_WC_RESET       32'h0000_0000

`endif

//--- rtl/dbm_skid_buffer.v
// two-entry valid/ready buffer for the receive data path
`timescale 1ns/1ps
`default_nettype none

module dbm_skid_buffer #(
    parameter WIDTH = 18,
    parameter DEPTH = 2
) (
    input  wire             clk_in,
    input  wire             nrst_in,
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // storage, read straight from flops
    reg             wr_ptr_reg;          // write slot
    reg             rd_ptr_reg;          // read slot
    reg [1:0]       count_reg;           // occupancy 0..2

    wire push = in_valid_in & in_ready_out;
    wire pop  = out_valid_out & out_ready_in;

    // full refuses the source, so a stalled drain never drops a word
    assign in_ready_out  = (count_reg != 2'h2);
    assign out_valid_out = (count_reg != 2'h0);
    assign out_data_out  = mem_reg[rd_ptr_reg];

    // storage write, no reset needed on data
    always @(posedge clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    // pointers and occupancy
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end
endmodule

`default_nettype wire

//--- sim/dbm_mem_model.sv
// system memory: byte store, ack after a set number of waits
`timescale 1ns/1ps
`default_nettype none
module dbm_mem_model (
    input  wire logic        clk_in,
    input  wire logic        req_in,
    input  wire logic        we_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic [1:0]  delay_in,
    output var  logic        ack_out = 1'h0,
    output var  logic [15:0] rdata_out = 16'h5A5A
);
    logic [7:0] mem [0:8191];    // low address bits only
    logic [1:0] wait_reg = 2'h0; // waits spent on this request
    // data churns outside the ack cycle so stale values never pass
    always @(posedge clk_in) begin
        ack_out <= 1'h0;
        rdata_out <= ~rdata_out;
        wait_reg <= 2'h0;
        if (req_in && !ack_out && wait_reg != delay_in) begin
            wait_reg <= wait_reg + 2'h1;
        end else if (req_in && !ack_out) begin
            ack_out <= 1'h1;
            rdata_out <= {mem[addr_in[12:0] + 13'h1], mem[addr_in[12:0]]};
            if (we_in) begin
                mem[addr_in[12:0]] <= wdata_in[7:0];
                mem[addr_in[12:0] + 13'h1] <= wdata_in[15:8];
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/dbm_mgr_sva.sv
// port assertions for the buffer manager
`timescale 1ns/1ps
`default_nettype none
module dbm_mgr_sva (
    input wire logic        clk_in,
    input wire logic        nrst_in,
    input wire logic        mem_req_out,
    input wire logic        mem_we_out,
    input wire logic        mem_ack_in,
    input wire logic [31:0] mem_addr_out,
    input wire logic [15:0] tx_upper_in,
    input wire logic [15:0] tx_first_desc_in,
    input wire logic        tx_start_in,
    input wire logic        tx_busy_out,
    input wire logic        tx_valid_out,
    input wire logic [7:0]  tx_data_out,
    input wire logic        tx_ready_in,
    input wire logic        tx_status_valid_in,
    input wire logic        rx_enable_in,
    input wire logic        rx_desc_exhausted_out,
    input wire logic        rx_pkt_done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // a completed write to memory
    sequence wr_done;
        mem_req_out && mem_we_out && mem_ack_in;
    endsequence
    req_hold_a: assert property (
        mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out)) else $error("req");
    tx_hold_a: assert property (
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out)) else $error("tx");
    first_addr_a: assert property (
        tx_start_in && !tx_busy_out && !rx_enable_in |=> mem_req_out
        && mem_addr_out == {$past(tx_upper_in), $past(tx_first_desc_in) + 16'h0004})
        else $error("first address");
    start_take_a: assert property (tx_start_in |=> tx_busy_out) else $error("start");
    status_wb_a: assert property (
        tx_status_valid_in |-> ##[1:100] wr_done) else $error("status write");
    done_pulse_a: assert property (
        rx_pkt_done_out |=> !rx_pkt_done_out) else $error("done pulse");
    wr_align_a: assert property (
        mem_req_out && mem_we_out |-> !mem_addr_out[0]) else $error("alignment");
    rx_off_a: assert property (
        !rx_enable_in [*2] |-> rx_desc_exhausted_out) else $error("disabled list");
endmodule
bind dbm_buffer_manager dbm_mgr_sva i_sva (.*);
`default_nettype wire

//--- sim/testbench.sv
// bench: transmit gather walk and receive buffering
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_in = 1'h0, nrst_in = 1'h0, tx_start_in = 1'h0, tx_ready_in = 1'h0;
    logic tx_status_valid_in = 1'h0, rx_enable_in = 1'h0, rx_valid_in = 1'h0, pend;
    logic rx_last_in = 1'h0, rx_last_odd_in = 1'h0, mem_req_out, mem_we_out, mem_ack_in;
    logic tx_busy_out, tx_valid_out, tx_last_out, rx_ready_out, rx_pkt_done_out;
    logic rx_desc_exhausted_out, rx_rsrc_empty_out;
    logic [31:0] mem_addr_out;
    logic [15:0] mem_wdata_out, mem_rdata_in, tx_pkt_size_out, tx_status_in = 16'h0;
    logic [15:0] tx_first_desc_in = 16'h0, rx_first_desc_in = 16'h0C00, rx_data_in = 16'h0;
    logic [15:0] rsrc_write_ptr_in = 16'h0800, rx_status_in = 16'h0101, tx_upper_in = 16'h0001;
    logic [7:0] tx_data_out;
    logic [1:0] mem_delay = 2'h0; // prompt for transmit, slow for receive
    int fails = 0, cmp_count = 0, cyc = 0, done_cnt = 0;
    // {byte address, word}: two linked transmit descriptors, resources, receive links
    logic [31:0] img [27] = '{32'h01040040, 32'h01080002, 32'h010C0401, 32'h01100001,
        32'h01140006, 32'h01180500, 32'h011C0001, 32'h0120003A, 32'h01240200,
        32'h02040040, 32'h02080001, 32'h020C0601, 32'h02100001, 32'h02140040,
        32'h02180001, 32'h08001000, 32'h08040001, 32'h0808000C, 32'h080C0000,
        32'h08101100, 32'h08140001, 32'h08180040, 32'h081C0000, 32'h0C100C20,
        32'h0C14FFFF, 32'h0C300C40, 32'h0C34FFFF};
    dbm_buffer_manager #(.EOBC_WORDS(16'd8)) i_dut (
        .rx_desc_upper_in(16'h0001), .rsrc_upper_in(16'h0001), .rsrc_start_in(16'h0800),
        .rsrc_end_in(16'h0830), .*);
    dbm_mem_model i_mem (.clk_in(clk_in), .req_in(mem_req_out), .we_in(mem_we_out),
        .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .delay_in(mem_delay),
        .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
    always #20 clk_in = ~clk_in;
    // done pulses, counted off the clock edge
    always @(negedge clk_in) done_cnt += (rx_pkt_done_out === 1'h1);
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [15:0] r16(input int a);
        return {i_mem.mem[a + 1], i_mem.mem[a]};
    endfunction
    // gather 6+58 and 64 bytes with a stalling sink, then status write-back
    task automatic tx_test;
        int k;
        int a;
        @(negedge clk_in);
        tx_first_desc_in = 16'h0100;
        tx_start_in = 1'h1;
        @(negedge clk_in);
        tx_start_in = 1'h0;
        pend = 1'h0;
        for (k = 0; k < 128;) begin
            @(negedge clk_in);
            tx_status_valid_in = pend;
            pend = 1'h0;
            tx_ready_in = ~tx_ready_in;
            if (tx_valid_out && tx_ready_in) begin
                a = k < 6 ? 'h401 + k : k < 64 ? 'h4FA + k : 'h5C1 + k;
                chk("tx byte", {8'h0, 8'(a) ^ 8'h5A}, {8'h0, tx_data_out});
                chk("tx last", 16'(k % 64 == 63), 16'(tx_last_out));
                k++;
                pend = (k == 64);
                tx_status_in = 16'hC000 + 16'(k);
            end
        end
        repeat (2) @(negedge clk_in) tx_status_valid_in = ~tx_status_valid_in;
        for (k = 0; k < 300 && tx_busy_out; k++) @(negedge clk_in);
        chk("tx busy", 16'h0, 16'(tx_busy_out));
        chk("tx size", 16'h0040, tx_pkt_size_out);
        chk("tx status 0", 16'hC040, r16('h100));
        chk("tx status 1", 16'hC080, r16('h200));
    endtask
    // two packets share one buffer, then low room pulls the next resource
    task automatic rx_test;
        int k;
        int t;
        @(negedge clk_in);
        rsrc_write_ptr_in = 16'h0820;
        rx_enable_in = 1'h1;
        for (k = 0; k < 6; k++) begin
            @(negedge clk_in);
            rx_valid_in = 1'h1;
            rx_data_in = 16'hA000 + 16'(k);
            rx_last_in = (k % 3 == 2);
            rx_last_odd_in = (k == 5);
            for (t = 0; t < 300 && !rx_ready_out; t++) @(negedge clk_in);
        end
        @(negedge clk_in);
        rx_valid_in = 1'h0;
        for (t = 0; t < 600 && !(done_cnt == 2 && rx_rsrc_empty_out); t++) @(negedge clk_in);
        chk("rx done", 16'h2, 16'(done_cnt));
        chk("rsrc empty", 16'h1, 16'(rx_rsrc_empty_out));
        chk("rsrc kept", 16'h1000, r16('h800));
        for (k = 0; k < 6; k++) chk("rx word", k == 5 ? 16'h0005 : 16'hA000 + 16'(k),
            r16('h1000 + 2 * k) & (k == 5 ? 16'h00FF : 16'hFFFF));
        for (k = 0; k < 2; k++) begin
            chk("rx status", 16'h0101, r16('hC00 + 'h20 * k));
            chk("rx count", k ? 16'h5 : 16'h6, r16('hC04 + 'h20 * k));
            chk("rx ptr", 16'h1000 + 16'(6 * k), r16('hC08 + 'h20 * k));
            chk("rx ptr hi", 16'h0001, r16('hC0C + 'h20 * k));
            chk("rx in use", 16'h0, r16('hC14 + 'h20 * k));
        end
        rx_enable_in = 1'h0;
        repeat (2) @(negedge clk_in);
        chk("rx exhausted", 16'h1, 16'(rx_desc_exhausted_out));
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 8192; i++) i_mem.mem[i] = 8'(i) ^ 8'h5A;
        foreach (img[i]) {i_mem.mem[img[i][31:16] + 1], i_mem.mem[img[i][31:16]]} = img[i][15:0];
        repeat (8) @(negedge clk_in);
        nrst_in = 1'h1;
        tx_test();
        mem_delay = 2'h2;
        rx_test();
        test_done();
    end
endmodule
`default_nettype wire
